// ### common/rcip_pkg.sv
// constants for the reset pin, bus clock and interrupt pin logic
// assumes a single 100 MHz oscillator clock and a 32-bit classic wishbone slave port
package rcip_pkg;
  // ==========================================================================
  // timing: reset drive and sample in bus cycles, base bus period in oscillator clocks
  localparam logic [4:0] RST_DRIVE_TICKS  = 5'h10;
  localparam logic [4:0] RST_SAMPLE_TICKS = 5'h08;
  localparam logic [3:0] BUS_BASE_PERIOD  = 4'h2;
  // ==========================================================================
  // register byte offsets
  localparam logic [3:0] ADR_CLK_CTRL = 4'h0;
  localparam logic [3:0] ADR_IRQ_CTRL = 4'h4;
  localparam logic [3:0] ADR_CCR      = 4'h8;
  localparam logic [3:0] ADR_STATUS   = 4'hC;
  // ==========================================================================
  // field positions
  localparam int CLK_EN_BIT     = 0;
  localparam int STR_EN_BIT     = 1;
  localparam int STR_CNT_LSB    = 2;
  localparam int IRQ_EDGE_BIT   = 0;
  localparam int CCR_IMASK_BIT  = 0;
  localparam int ST_PIN_BIT     = 0;
  localparam int ST_PEND_BIT    = 1;
  localparam int ST_VEC_LSB     = 2;
  localparam int ST_RST_LSB     = 4;
  localparam int ST_MODE_LSB    = 6;
  // ==========================================================================
  // reset values
  localparam logic       RST_IRQ_EDGE  = 1'b0;
  localparam logic       RST_IMASK     = 1'b1;
  localparam logic       RST_STR_EN    = 1'b0;
  localparam logic [1:0] RST_STR_CNT   = 2'h0;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    MODE_NORM_SC = 2'h0, MODE_SPEC_SC = 2'h1, MODE_SPEC_PERIPH = 2'h2, MODE_NORM_EXP = 2'h3
  } mode_t;
  typedef enum logic [1:0] {VEC_EXT = 2'h0, VEC_WDOG = 2'h1, VEC_CLKMON = 2'h2} vec_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_DRIVE = 2'h1, ST_WAIT = 2'h3, ST_EXT = 2'h2} rst_st_t;
endpackage : rcip_pkg

// ### common/sync_if.sv
// bundle between the pin synchroniser and its user
// assumes raw is driven by the user and synced is read back on the same clock
`timescale 1ns/1ps
`default_nettype none
interface sync_if #(parameter int W = 3);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface : sync_if
`default_nettype wire

// ### rtl/pin_sync.sv
// two-stage synchroniser for a group of pin levels
// assumes pins idle high, so both stages reset to ones
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic clk,      // oscillator clock
  input  wire logic rst,      // synchronous reset, active high
  sync_if.sync      sif       // raw pins in, synced levels out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // ==========================================================================
  // meta stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= sif.raw;
      sync_reg <= meta_reg;
    end
  end

  assign sif.synced = sync_reg;
endmodule : pin_sync
`default_nettype wire

// ### rtl/reset_clock_irq_pin_logic.sv
// reset pin sequencer, bus clock generator and maskable interrupt pin logic
// assumes REF_CLK is the oscillator input and software uses a classic wishbone master
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module reset_clock_irq_pin_logic
  import rcip_pkg::*;
#(
  parameter logic [4:0] DRIVE_TICKS  = RST_DRIVE_TICKS,
  parameter logic [4:0] SAMPLE_TICKS = RST_SAMPLE_TICKS
) (
  input  wire logic        REF_CLK,          // oscillator clock, 100 MHz
  input  wire logic        RESET,            // synchronous reset, active high
  input  wire logic [1:0]  MODE_I,           // operating mode straps
  input  wire logic        WDOG_FAIL_I,      // watchdog timeout pulse
  input  wire logic        CLKMON_FAIL_I,    // clock monitor failure pulse
  input  wire logic        STOP_I,           // stop mode level
  input  wire logic        EXT_ACCESS_I,     // slow external access level
  input  wire logic        IRQ_ACK_I,        // cpu acknowledge pulse
  input  wire logic        RESET_PIN_I,      // reset pin level
  output logic             RESET_PIN_O,      // reset pin drive value
  output logic             RESET_PIN_OE,     // reset pin drive enable
  output logic             CORE_RESET,       // core reset, active high
  output logic [1:0]       VECTOR_SEL,       // vector to fetch
  input  wire logic        BUS_CLOCK_I,      // bus clock pin level
  output logic             BUS_CLOCK_O,      // bus clock pin drive value
  output logic             BUS_CLOCK_OE,     // bus clock pin drive enable
  output logic             BUS_TICK,         // one pulse per bus cycle
  input  wire logic        IRQ_PIN_I,        // interrupt pin, active low
  output logic             IRQ_REQ,          // interrupt request to cpu
  input  wire logic        WB_CYC_I,         // wishbone cycle
  input  wire logic        WB_STB_I,         // wishbone strobe
  input  wire logic        WB_WE_I,          // wishbone write enable
  input  wire logic [3:0]  WB_ADR_I,         // wishbone byte address
  input  wire logic [3:0]  WB_SEL_I,         // wishbone byte selects
  input  wire logic [31:0] WB_DAT_I,         // wishbone write data
  output logic [31:0]      WB_DAT_O,         // wishbone read data
  output logic             WB_ACK_O          // wishbone acknowledge
);
  // ==========================================================================
  // declarations
  sync_if #(.W(3)) sif ();
  logic       rst_pin_s;
  logic       irq_s;
  logic       bclk_s;
  mode_t      mode_reg;
  rst_st_t    st_reg;
  logic [4:0] cnt_reg;
  vec_t       cause_reg;
  vec_t       vec_reg;
  logic       fail_any;
  logic       periph;
  logic       run;
  logic       stretch_now;
  logic [3:0] period;
  logic [3:0] div_reg;
  logic [3:0] div_next;
  logic       clk_reg;
  logic       bclk_prev_reg;
  logic       clk_en_reg;
  logic       str_en_reg;
  logic [1:0] str_cnt_reg;
  logic       edge_mode_reg;
  logic       imask_reg;
  logic       irq_prev_reg;
  logic       edge_pend_reg;
  logic       pending;
  logic       ack_reg;
  logic [31:0] dat_reg;
  logic       wb_req;
  logic       wb_wr;

  function automatic logic [3:0] period_f(input logic on, input logic [1:0] extra);
    period_f = on ? (BUS_BASE_PERIOD + {1'b0, extra, 1'b0}) : BUS_BASE_PERIOD;
  endfunction : period_f

  // ==========================================================================
  // pin synchronisers
  assign sif.raw = {BUS_CLOCK_I, IRQ_PIN_I, RESET_PIN_I};
  pin_sync #(.W(3)) u_sync (
    .clk (REF_CLK),
    .rst (RESET),
    .sif (sif)
  );
  assign rst_pin_s = sif.synced[0];
  assign irq_s     = sif.synced[1];
  assign bclk_s    = sif.synced[2];

  // straps are caught while the reset input is held
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      mode_reg <= mode_t'(MODE_I);
    end
  end

  // ==========================================================================
  // bus clock divider
  assign periph      = (mode_reg == MODE_SPEC_PERIPH);
  assign run         = !STOP_I && !periph;
  assign stretch_now = str_en_reg && EXT_ACCESS_I;
  assign period      = period_f(stretch_now, str_cnt_reg);
  assign div_next    = (div_reg >= period - 4'h1) ? 4'h0 : div_reg + 4'h1;

  always_comb begin
    if (periph) begin
      BUS_TICK = bclk_s && !bclk_prev_reg && !STOP_I;
    end else begin
      BUS_TICK = run && (div_reg >= period - 4'h1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      div_reg <= 4'h0;
      clk_reg <= 1'b0;
    end else if (run) begin
      div_reg <= div_next;
      clk_reg <= (div_next >= {1'b0, period[3:1]});
    end else begin
      clk_reg <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      bclk_prev_reg <= 1'b1;
    end else begin
      bclk_prev_reg <= bclk_s;
    end
  end

  assign BUS_CLOCK_O  = clk_reg;
  assign BUS_CLOCK_OE = clk_en_reg && !periph;

  // ==========================================================================
  // reset pin sequencer
  assign fail_any = WDOG_FAIL_I || CLKMON_FAIL_I;

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      st_reg    <= ST_IDLE;
      cnt_reg   <= 5'h00;
      cause_reg <= VEC_EXT;
      vec_reg   <= VEC_EXT;
    end else begin
      case (st_reg)
        ST_IDLE: begin
          if (!rst_pin_s) begin
            st_reg  <= ST_EXT;
            vec_reg <= VEC_EXT;
          end else if (fail_any) begin
            st_reg    <= ST_DRIVE;
            cnt_reg   <= 5'h00;
            cause_reg <= WDOG_FAIL_I ? VEC_WDOG : VEC_CLKMON;
          end
        end
        ST_DRIVE: begin
          if (BUS_TICK) begin
            if (cnt_reg == DRIVE_TICKS - 5'h01) begin
              st_reg  <= ST_WAIT;
              cnt_reg <= 5'h00;
            end else begin
              cnt_reg <= cnt_reg + 5'h01;
            end
          end
        end
        ST_WAIT: begin
          if (BUS_TICK) begin
            if (cnt_reg == SAMPLE_TICKS - 5'h01) begin
              if (rst_pin_s) begin
                st_reg  <= ST_IDLE;
                vec_reg <= cause_reg;
              end else begin
                st_reg  <= ST_EXT;
                vec_reg <= VEC_EXT;
              end
            end else begin
              cnt_reg <= cnt_reg + 5'h01;
            end
          end
        end
        ST_EXT: begin
          if (rst_pin_s) begin
            st_reg <= ST_IDLE;
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  assign RESET_PIN_O  = 1'b0;
  assign RESET_PIN_OE = (st_reg == ST_DRIVE);
  // raw pin enters reset with no clock; exit waits for the synced level
  assign CORE_RESET   = RESET || !RESET_PIN_I || (st_reg != ST_IDLE);
  assign VECTOR_SEL   = vec_reg;

  // ==========================================================================
  // interrupt pin
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      irq_prev_reg  <= 1'b1;
      edge_pend_reg <= 1'b0;
    end else begin
      irq_prev_reg <= irq_s;
      // a new edge beats an acknowledge in the same cycle
      if (edge_mode_reg && irq_prev_reg && !irq_s) begin
        edge_pend_reg <= 1'b1;
      end else if (IRQ_ACK_I || !edge_mode_reg) begin
        edge_pend_reg <= 1'b0;
      end
    end
  end

  // level sources keep the line low until acknowledged, so no latch here
  assign pending = edge_mode_reg ? edge_pend_reg : !irq_s;
  assign IRQ_REQ = pending && !imask_reg;

  // ==========================================================================
  // wishbone slave, one wait state
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_reg;
  assign wb_wr  = wb_req && WB_WE_I && WB_SEL_I[0];

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_req;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      clk_en_reg  <= (MODE_I != MODE_NORM_SC);
      str_en_reg  <= RST_STR_EN;
      str_cnt_reg <= RST_STR_CNT;
    end else if (wb_wr && WB_ADR_I == ADR_CLK_CTRL) begin
      clk_en_reg  <= WB_DAT_I[CLK_EN_BIT];
      str_en_reg  <= WB_DAT_I[STR_EN_BIT];
      str_cnt_reg <= WB_DAT_I[STR_CNT_LSB +: 2];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      edge_mode_reg <= RST_IRQ_EDGE;
      imask_reg     <= RST_IMASK;
    end else if (wb_wr && WB_ADR_I == ADR_IRQ_CTRL) begin
      edge_mode_reg <= WB_DAT_I[IRQ_EDGE_BIT];
    end else if (wb_wr && WB_ADR_I == ADR_CCR) begin
      imask_reg <= WB_DAT_I[CCR_IMASK_BIT];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      dat_reg <= 32'h0000_0000;
    end else if (wb_req) begin
      dat_reg <= 32'h0000_0000;
      case (WB_ADR_I)
        ADR_CLK_CTRL: begin
          dat_reg[CLK_EN_BIT]          <= clk_en_reg;
          dat_reg[STR_EN_BIT]          <= str_en_reg;
          dat_reg[STR_CNT_LSB +: 2]    <= str_cnt_reg;
        end
        ADR_IRQ_CTRL: begin
          dat_reg[IRQ_EDGE_BIT] <= edge_mode_reg;
        end
        ADR_CCR: begin
          dat_reg[CCR_IMASK_BIT] <= imask_reg;
        end
        ADR_STATUS: begin
          dat_reg[ST_PIN_BIT]        <= irq_s;
          dat_reg[ST_PEND_BIT]       <= pending;
          dat_reg[ST_VEC_LSB +: 2]   <= vec_reg;
          dat_reg[ST_RST_LSB +: 2]   <= st_reg;
          dat_reg[ST_MODE_LSB +: 2]  <= mode_reg;
        end
        default: begin
          dat_reg <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = dat_reg;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  logic [4:0] oe_ticks_reg;
  always_ff @(posedge REF_CLK) begin
    if (RESET || !RESET_PIN_OE) begin
      oe_ticks_reg <= 5'h00;
    end else if (BUS_TICK) begin
      oe_ticks_reg <= oe_ticks_reg + 5'h01;
    end
  end

  sequence s_sample;
    st_reg == ST_WAIT && BUS_TICK && cnt_reg == SAMPLE_TICKS - 5'h01;
  endsequence

  property p_async_entry;
    !RESET_PIN_I |-> CORE_RESET;
  endproperty
  a_async_entry: assert property (p_async_entry) else $error("pin low without core reset");

  property p_drive_cause;
    $rose(RESET_PIN_OE) |-> $past(fail_any) && !RESET_PIN_O;
  endproperty
  a_drive_cause: assert property (p_drive_cause) else $error("pin driven without failure");

  property p_drive_len;
    $fell(RESET_PIN_OE) |-> $past(oe_ticks_reg) == DRIVE_TICKS - 5'h01 && st_reg == ST_WAIT;
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("pin drive length wrong");

  property p_vec_int;
    s_sample ##0 rst_pin_s |=> VECTOR_SEL == $past(cause_reg) && st_reg == ST_IDLE;
  endproperty
  a_vec_int: assert property (p_vec_int) else $error("internal vector not taken");

  property p_vec_ext;
    s_sample ##0 !rst_pin_s |=> VECTOR_SEL == VEC_EXT && CORE_RESET;
  endproperty
  a_vec_ext: assert property (p_vec_ext) else $error("external vector not taken");

  property p_half_rate;
    BUS_TICK && !periph ##1 (run && !stretch_now)[*2] |-> BUS_TICK;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("bus cycle not two clocks");

  property p_clk_reset_en;
    $past(RESET) |-> BUS_CLOCK_OE == (mode_reg == MODE_SPEC_SC || mode_reg == MODE_NORM_EXP);
  endproperty
  a_clk_reset_en: assert property (p_clk_reset_en) else $error("clock output reset state wrong");

  property p_periph_in;
    periph |-> !BUS_CLOCK_OE && !BUS_CLOCK_O;
  endproperty
  a_periph_in: assert property (p_periph_in) else $error("bus clock driven as input");

  property p_stop;
    STOP_I |-> !BUS_TICK ##1 !BUS_CLOCK_O;
  endproperty
  a_stop: assert property (p_stop) else $error("clock runs in stop");

  property p_reset_irq;
    $past(RESET) |-> imask_reg && !edge_mode_reg && !IRQ_REQ;
  endproperty
  a_reset_irq: assert property (p_reset_irq) else $error("interrupt reset state wrong");

  property p_edge;
    edge_mode_reg && $fell(irq_s) |=> edge_pend_reg;
  endproperty
  a_edge: assert property (p_edge) else $error("falling edge lost");

  property p_unmask;
    $fell(imask_reg) && !edge_mode_reg && !irq_s |-> IRQ_REQ;
  endproperty
  a_unmask: assert property (p_unmask) else $error("held line not recognised");
endmodule : reset_clock_irq_pin_logic
`default_nettype wire

// ### verification/rcip_far_side.sv
// board side of the block: reset pin pull-up, interrupt source, bus clock source
// assumes one clock shared with the bench and open-drain pins with pull-ups
`timescale 1ns/1ps
`default_nettype none
module rcip_far_side (
  input  wire logic       clk,       // oscillator clock
  input  wire logic       pin_oe,    // block pulls reset pin
  input  wire logic       pin_o,     // block reset pin value
  input  wire logic       ext_low,   // board reset switch held
  input  wire logic       irq_low,   // interrupt source asserting
  input  wire logic       bclk_run,  // external bus clock running
  input  wire logic [3:0] bclk_half, // half period in clocks
  output logic            reset_pin, // wired reset pin level
  output logic            irq_pin,   // wired interrupt pin level
  output logic            bus_clk    // supplied bus clock
);
  logic [3:0] half_cnt_reg;
  // ==========================================================================
  // wired pins: pull-ups win only when nobody drives low
  assign reset_pin = ((pin_oe && !pin_o) || ext_low) ? 1'b0 : 1'b1;
  assign irq_pin   = irq_low ? 1'b0 : 1'b1;
  // ==========================================================================
  // bus clock supplied in peripheral mode, parked low when not running
  always_ff @(posedge clk) begin
    if (!bclk_run) begin
      half_cnt_reg <= 4'h0;
      bus_clk      <= 1'b0;
    end else if (half_cnt_reg == bclk_half - 4'h1) begin
      half_cnt_reg <= 4'h0;
      bus_clk      <= !bus_clk;
    end else begin
      half_cnt_reg <= half_cnt_reg + 4'h1;
    end
  end
endmodule : rcip_far_side
`default_nettype wire

// ### verification/test_reset_clock_irq_pin_logic.sv
// self-checking bench for the reset, bus clock and interrupt pin block
// assumes the far side model and a classic wishbone master in tasks
`timescale 1ns/1ps
`default_nettype none
module test_reset_clock_irq_pin_logic
  import rcip_pkg::*;
;
  logic        ref_clk, reset, wdog, clkmon, stop, ext_acc, ack_irq;
  logic [1:0]  mode;
  logic        ext_low, irq_low, bclk_run;
  logic        cyc, stb, we;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, dat_o;
  logic        pin_o, pin_oe, core_rst, bclk_o, bclk_oe, tick, irq_req, ack;
  logic        reset_pin, irq_pin, bus_clk;
  logic [1:0]  vec;
  int          errors, tests_run, n, p;
  reset_clock_irq_pin_logic dut_u (
    .REF_CLK(ref_clk), .RESET(reset), .MODE_I(mode), .WDOG_FAIL_I(wdog),
    .CLKMON_FAIL_I(clkmon), .STOP_I(stop), .EXT_ACCESS_I(ext_acc), .IRQ_ACK_I(ack_irq),
    .RESET_PIN_I(reset_pin), .RESET_PIN_O(pin_o), .RESET_PIN_OE(pin_oe),
    .CORE_RESET(core_rst), .VECTOR_SEL(vec), .BUS_CLOCK_I(bus_clk), .BUS_CLOCK_O(bclk_o),
    .BUS_CLOCK_OE(bclk_oe), .BUS_TICK(tick), .IRQ_PIN_I(irq_pin), .IRQ_REQ(irq_req),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack));
  rcip_far_side far_u (
    .clk(ref_clk), .pin_oe(pin_oe), .pin_o(pin_o), .ext_low(ext_low), .irq_low(irq_low),
    .bclk_run(bclk_run), .bclk_half(4'h3), .reset_pin(reset_pin), .irq_pin(irq_pin),
    .bus_clk(bus_clk));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end
  // ==========================================================================
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    for (int i = 0; i <= 50; i++) begin
      if (i == 50) begin errors++; report_and_stop(); end
      @(posedge ref_clk);
      if (ack === 1'b1) break;
    end
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0;
  endtask : wb
  // outputs are combinational, so they are looked at on the falling edge
  task automatic wait_sig(input int sel, input logic val, output int cnt);
    logic v;
    for (cnt = 1; cnt <= 2000; cnt++) begin
      @(negedge ref_clk);
      case (sel)
        0: v = pin_oe;
        1: v = core_rst;
        2: v = tick;
        default: v = irq_req;
      endcase
      if (v === val) return;
    end
    errors++;
    report_and_stop();
  endtask : wait_sig
  task automatic tick_period(output int per);
    wait_sig(2, 1'b1, per);
    wait_sig(2, 1'b1, per);
  endtask : tick_period
  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk);
  endtask : idle
  task automatic apply_reset(input logic [1:0] m);
    @(posedge ref_clk);
    reset <= 1'b1; mode <= m;
    idle(10);
    reset <= 1'b0;
    idle(3);
  endtask : apply_reset
  task automatic internal_fail(input logic cm, input logic hold, input logic [1:0] v);
    @(posedge ref_clk);
    wdog <= !cm; clkmon <= cm; ext_low <= hold;
    @(posedge ref_clk);
    wdog <= 1'b0; clkmon <= 1'b0;
    if (hold) check("async entry", core_rst, 1'b1);
    wait_sig(0, 1'b1, n);
    check("pin pulled low", reset_pin, 1'b0);
    wait_sig(0, 1'b0, n);
    check("drive length", 32'(n >= 31 && n <= 32), 1);
    if (hold) begin
      idle(40);
      ext_low <= 1'b0;
    end
    wait_sig(1, 1'b0, n);
    if (!hold) check("sample delay", 32'(n >= 15 && n <= 18), 1);
    check("vector", vec, v);
    $display("test reset source %0d done", v);
  endtask : internal_fail
  // ==========================================================================
  // main sequence
  initial begin
    errors = 0; tests_run = 0;
    reset = 1'b1; mode = 2'h0; wdog = 1'b0; clkmon = 1'b0; stop = 1'b0; ext_acc = 1'b0;
    ack_irq = 1'b0; ext_low = 1'b0; irq_low = 1'b0; bclk_run = 1'b0;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; wdat = 32'h0;
    for (int m = 0; m < 4; m++) begin
      bclk_run <= (m == 2);
      apply_reset(2'(m));
      check("clock out enable", bclk_oe, 1'(m == 1 || m == 3));
      tick_period(p);
      check("tick period", p, m == 2 ? 6 : 2);
      check("clock out level at tick", bclk_o, 1'(m != 2));
      wb(1'b0, ADR_STATUS, 32'h0);
      check("status after reset", rdat, (32'(m) << ST_MODE_LSB) | 32'h1);
      $display("test mode %0d done", m);
    end
    bclk_run <= 1'b0;
    apply_reset(MODE_SPEC_SC);
    wb(1'b1, ADR_CLK_CTRL, 32'h0);
    idle(2);
    check("clock out disabled", bclk_oe, 1'b0);
    apply_reset(MODE_NORM_SC);
    wb(1'b0, ADR_IRQ_CTRL, 32'h0); check("irq ctrl reset", rdat, 32'h0);
    wb(1'b0, ADR_CCR, 32'h0);      check("mask reset", rdat, 32'h1);
    wb(1'b0, 4'h2, 32'h0);         check("unmapped read", rdat, 32'h0);
    wb(1'b1, ADR_CLK_CTRL, 32'h7);
    idle(2);
    check("clock out enabled", bclk_oe, 1'b1);
    @(posedge ref_clk) ext_acc <= 1'b1;
    tick_period(p); tick_period(p);
    check("stretched period", p, 4);
    @(posedge ref_clk) begin ext_acc <= 1'b0; stop <= 1'b1; end
    idle(3);
    n = 0;
    repeat (20) begin @(negedge ref_clk); if (tick !== 1'b0) n++; end
    check("ticks in stop", n, 0);
    check("clock out in stop", bclk_o, 1'b0);
    @(posedge ref_clk) stop <= 1'b0;
    $display("test bus clock done");
    internal_fail(1'b0, 1'b0, VEC_WDOG);
    wb(1'b0, ADR_STATUS, 32'h0);
    check("status vector", rdat[ST_VEC_LSB +: 2], VEC_WDOG);
    internal_fail(1'b1, 1'b0, VEC_CLKMON);
    internal_fail(1'b0, 1'b1, VEC_EXT);
    // interrupt pin, level then edge triggering
    @(posedge ref_clk) irq_low <= 1'b1;
    idle(6);
    check("masked request", irq_req, 1'b0);
    wb(1'b0, ADR_STATUS, 32'h0);
    check("pin level read", rdat[ST_PIN_BIT], 1'b0);
    wb(1'b1, ADR_CCR, 32'h0);
    wait_sig(3, 1'b1, n);
    check("request on unmask", 32'(n <= 3), 1);
    @(posedge ref_clk) irq_low <= 1'b0;
    wait_sig(3, 1'b0, n);
    @(posedge ref_clk) irq_low <= 1'b1;
    wait_sig(3, 1'b1, n);
    check("pin latency", 32'(n >= 2 && n <= 4), 1);
    @(posedge ref_clk) irq_low <= 1'b0;
    wb(1'b1, ADR_IRQ_CTRL, 32'h1);
    idle(4);
    check("no edge yet", irq_req, 1'b0);
    @(posedge ref_clk) irq_low <= 1'b1;
    idle(2);
    irq_low <= 1'b0;
    idle(6);
    check("edge latched", irq_req, 1'b1);
    wb(1'b0, ADR_STATUS, 32'h0);
    check("edge pending", rdat[ST_PEND_BIT], 1'b1);
    @(posedge ref_clk) ack_irq <= 1'b1;
    @(posedge ref_clk) ack_irq <= 1'b0;
    idle(2);
    check("edge cleared", irq_req, 1'b0);
    apply_reset(MODE_NORM_SC);
    wb(1'b0, ADR_IRQ_CTRL, 32'h0); check("level after reset", rdat, 32'h0);
    $display("test interrupt done");
    report_and_stop();
  end
endmodule : test_reset_clock_irq_pin_logic
`default_nettype wire
